// ### design/isf_pkg.sv
// shared constants for the first-status-register flag block
package isf_pkg;

  // register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_STATUS_ONE = 3'h1;
  localparam logic [2:0] OFS_STATUS_TWO = 3'h2;
  localparam logic [2:0] OFS_DATA = 3'h3;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h4;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h5;

  // control register fields
  localparam int POS_PERIPH_EN = 5;
  localparam int POS_START_REQ = 3;
  localparam int POS_ACK_EN = 2;
  localparam int POS_STOP_REQ = 1;
  localparam int POS_INT_EN = 0;

  // first status register fields
  localparam int POS_SUMMARY = 7;
  localparam int POS_HEADER = 6;
  localparam int POS_DIRECTION = 5;
  localparam int POS_BUSY = 4;
  localparam int POS_BYTE_DONE = 3;
  localparam int POS_ADDR_MATCH = 2;
  localparam int POS_MASTER = 1;
  localparam int POS_START_GEN = 0;

  // second status register fields
  localparam int POS_ACK_FAIL = 4;
  localparam int POS_STOP_DET = 3;
  localparam int POS_ARB_LOST = 2;
  localparam int POS_BUS_ERR = 1;

  // interrupt event bits, same layout in status and mask
  localparam int NUM_IEV = 8;
  localparam int IEV_BYTE_DONE = 0;
  localparam int IEV_ADDR_MATCH = 1;
  localparam int IEV_START_GEN = 2;
  localparam int IEV_HEADER = 3;
  localparam int IEV_ACK_FAIL = 4;
  localparam int IEV_STOP_DET = 5;
  localparam int IEV_ARB_LOST = 6;
  localparam int IEV_BUS_ERR = 7;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

  // which status register was read last, for the read-then-data clears
  typedef enum logic [2:0] {
    SEQ_NONE = 3'b001,
    SEQ_ONE = 3'b010,
    SEQ_TWO = 3'b100
  } isf_seq_t;

endpackage : isf_pkg

// ### design/isf_link_if.sv
// carrier between the flag core, the line watcher and the interrupt unit
`timescale 1ns/1ps
interface isf_link_if;
  import isf_pkg::*;
  logic start_seen;
  logic stop_seen;
  logic [NUM_IEV-1:0] ev_set;
  logic wr_stat;
  logic wr_mask;
  logic [DATA_W-1:0] wdata;
  logic gate;
  logic [NUM_IEV-1:0] stat;
  logic [NUM_IEV-1:0] mask;
  logic irq;

  modport watch (output start_seen, output stop_seen);
  modport irqu (input ev_set, input wr_stat, input wr_mask, input wdata, input gate,
    output stat, output mask, output irq);
  modport core (input start_seen, input stop_seen, input stat, input mask, input irq,
    output ev_set, output wr_stat, output wr_mask, output wdata, output gate);
endinterface : isf_link_if

// ### design/isf_line_watch.sv
// synchronises the bus lines and finds start and stop conditions
`timescale 1ns/1ps
module isf_line_watch
  import isf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  isf_link_if.watch link
);

  typedef struct packed {
    logic scl_meta;
    logic sda_meta;
    logic scl_sync;
    logic sda_sync;
    logic sda_prev;
    logic start_seen;
    logic stop_seen;
  } isf_watch_t;

  isf_watch_t s;
  isf_watch_t next_s;

  always_comb begin
    next_s = s;
    next_s.scl_meta = scl_i;
    next_s.sda_meta = sda_i;
    next_s.scl_sync = s.scl_meta;
    next_s.sda_sync = s.sda_meta;
    next_s.sda_prev = s.sda_sync;
    // data line moving while the clock line is high marks a condition
    next_s.start_seen = s.scl_sync && s.sda_prev && !s.sda_sync;
    next_s.stop_seen = s.scl_sync && !s.sda_prev && s.sda_sync;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{scl_meta: 1'b1, sda_meta: 1'b1, scl_sync: 1'b1, sda_sync: 1'b1,
             sda_prev: 1'b1, start_seen: 1'b0, stop_seen: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign link.start_seen = s.start_seen;
  assign link.stop_seen = s.stop_seen;

endmodule : isf_line_watch

// ### design/isf_irq_unit.sv
// sticky event status, mask and the level interrupt
`timescale 1ns/1ps
module isf_irq_unit
  import isf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  isf_link_if.irqu link
);

  typedef struct packed {
    logic [NUM_IEV-1:0] stat;
    logic [NUM_IEV-1:0] mask;
    logic irq;
  } isf_irq_t;

  isf_irq_t s;
  isf_irq_t next_s;
  logic [NUM_IEV-1:0] next_stat;

  // a new event in the clearing cycle survives the write of one
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IEV; gi++) begin : g_bit
      assign next_stat[gi] = link.ev_set[gi] || (s.stat[gi] && !(link.wr_stat && link.wdata[gi]));
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.stat = next_stat;
    if (link.wr_mask) begin
      next_s.mask = link.wdata[NUM_IEV-1:0];
    end
    next_s.irq = link.gate && |(next_s.stat & next_s.mask);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{stat: RST_BYTE, mask: RST_MASK, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign link.stat = s.stat;
  assign link.mask = s.mask;
  assign link.irq = s.irq;

endmodule : isf_irq_unit

// ### design/isf_status_one.sv
// flag logic of the first status register of a multimaster i2c interface
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module isf_status_one
  import isf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic ev_tx_byte_acked,
  input wire logic ev_rx_byte_acked,
  input wire logic ev_addr_acked,
  input wire logic ev_own_addr_match,
  input wire logic ev_start_issued,
  input wire logic ev_header_sent,
  input wire logic ev_ack_missing,
  input wire logic ev_arb_lost,
  input wire logic ev_misplaced_cond,
  input wire logic [DATA_W-1:0] rx_byte,
  output logic [DATA_W-1:0] tx_byte,
  output logic peripheral_enable,
  output logic start_request,
  output logic stop_request,
  output logic ack_enable,
  output logic master_mode_flag,
  output logic irq
);

  typedef struct packed {
    logic periph_en;
    logic start_req;
    logic ack_en;
    logic stop_req;
    logic int_en;
    logic summary;
    logic header;
    logic direction;
    logic busy;
    logic byte_done;
    logic addr_match;
    logic master;
    logic start_gen;
    logic ack_fail;
    logic stop_det;
    logic arb_lost;
    logic bus_err;
    logic slave_active;
    isf_seq_t seq;
    logic [DATA_W-1:0] tx_byte;
    logic [DATA_W-1:0] rdata;
    logic scl_out;
    logic scl_oe;
  } isf_core_t;

  isf_core_t s;
  isf_core_t next_s;

  isf_link_if link ();

  isf_line_watch u_watch (
    .clock(clock),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .link(link.watch)
  );

  isf_irq_unit u_irq (
    .clock(clock),
    .rst(rst),
    .link(link.irqu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register access decode

  logic wr_ctrl;
  logic rd_one;
  logic rd_two;
  logic wr_data;
  logic rd_data;
  logic wr_istat;
  logic wr_imask;

  assign wr_ctrl = wr_en && (addr == OFS_CTRL);
  assign rd_one = rd_en && (addr == OFS_STATUS_ONE);
  assign rd_two = rd_en && (addr == OFS_STATUS_TWO);
  assign wr_data = wr_en && (addr == OFS_DATA);
  assign rd_data = rd_en && (addr == OFS_DATA);
  assign wr_istat = wr_en && (addr == OFS_IRQ_STAT);
  assign wr_imask = wr_en && (addr == OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // hardware events, all ignored while disabled

  logic set_tx_done;
  logic set_rx_done;
  logic set_match;
  logic set_start;
  logic set_header;
  logic set_ack_fail;
  logic set_arb;
  logic set_bus_error_flag;
  logic set_stop_det;
  logic cond_start;
  logic cond_stop;

  // an address byte counts as done only once it was acknowledged
  assign set_tx_done = s.periph_en && (ev_tx_byte_acked || ev_addr_acked);
  assign set_rx_done = s.periph_en && ev_rx_byte_acked && s.ack_en;
  assign set_match = s.periph_en && ev_own_addr_match && s.ack_en;
  assign set_start = s.periph_en && ev_start_issued && s.start_req;
  assign set_header = s.periph_en && ev_header_sent;
  assign set_ack_fail = s.periph_en && ev_ack_missing;
  assign set_arb = s.periph_en && ev_arb_lost;
  assign set_bus_error_flag = s.periph_en && ev_misplaced_cond;
  assign cond_start = s.periph_en && link.start_seen;
  assign cond_stop = s.periph_en && link.stop_seen;
  assign set_stop_det = cond_stop && s.slave_active && s.ack_en;

  ////////////////////////////////////////////////////////////////////////////
  // clearing sequences

  logic after_one;
  logic clr_byte;
  logic clr_start;
  logic clr_header;

  assign after_one = (s.seq == SEQ_ONE);
  assign clr_byte = after_one && (wr_data || rd_data);
  assign clr_start = after_one && wr_data;
  assign clr_header = (s.seq == SEQ_TWO) && wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt unit hookup

  always_comb begin
    link.ev_set = RST_BYTE;
    link.ev_set[IEV_BYTE_DONE] = set_tx_done || set_rx_done;
    link.ev_set[IEV_ADDR_MATCH] = set_match;
    link.ev_set[IEV_START_GEN] = set_start;
    link.ev_set[IEV_HEADER] = set_header;
    link.ev_set[IEV_ACK_FAIL] = set_ack_fail;
    link.ev_set[IEV_STOP_DET] = set_stop_det;
    link.ev_set[IEV_ARB_LOST] = set_arb;
    link.ev_set[IEV_BUS_ERR] = set_bus_error_flag;
  end

  assign link.wr_stat = wr_istat;
  assign link.wr_mask = wr_imask;
  assign link.wdata = wdata;
  assign link.gate = s.int_en;

  ////////////////////////////////////////////////////////////////////////////
  // read views

  logic [DATA_W-1:0] view_ctrl;
  logic [DATA_W-1:0] view_one;
  logic [DATA_W-1:0] view_two;

  always_comb begin
    view_ctrl = RST_BYTE;
    view_ctrl[POS_PERIPH_EN] = s.periph_en;
    view_ctrl[POS_START_REQ] = s.start_req;
    view_ctrl[POS_ACK_EN] = s.ack_en;
    view_ctrl[POS_STOP_REQ] = s.stop_req;
    view_ctrl[POS_INT_EN] = s.int_en;
    view_one = RST_BYTE;
    view_one[POS_SUMMARY] = s.summary;
    view_one[POS_HEADER] = s.header;
    view_one[POS_DIRECTION] = s.direction;
    view_one[POS_BUSY] = s.busy;
    view_one[POS_BYTE_DONE] = s.byte_done;
    view_one[POS_ADDR_MATCH] = s.addr_match;
    view_one[POS_MASTER] = s.master;
    view_one[POS_START_GEN] = s.start_gen;
    view_two = RST_BYTE;
    view_two[POS_ACK_FAIL] = s.ack_fail;
    view_two[POS_STOP_DET] = s.stop_det;
    view_two[POS_ARB_LOST] = s.arb_lost;
    view_two[POS_BUS_ERR] = s.bus_err;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;

    // control register; while disabled a write only sets the enable and the stop request
    if (wr_ctrl) begin
      next_s.periph_en = wdata[POS_PERIPH_EN];
      next_s.stop_req = wdata[POS_STOP_REQ];
      if (s.periph_en) begin
        next_s.start_req = wdata[POS_START_REQ];
        next_s.ack_en = wdata[POS_ACK_EN];
        next_s.int_en = wdata[POS_INT_EN];
      end
    end else begin
      if (set_start) begin
        next_s.start_req = 1'b0;
      end
      if (s.master && cond_stop) begin
        next_s.stop_req = 1'b0;
      end
    end

    // byte finished and direction; a new byte beats a clear in the same cycle
    next_s.byte_done = set_tx_done || set_rx_done || (s.byte_done && !clr_byte);
    if (set_tx_done) begin
      next_s.direction = 1'b1;
    end else if (set_rx_done) begin
      next_s.direction = 1'b0;
    end else if (!next_s.byte_done || cond_stop || set_arb) begin
      next_s.direction = 1'b0;
    end

    next_s.addr_match = set_match || (s.addr_match && !rd_one);
    next_s.start_gen = set_start || (s.start_gen && !clr_start);
    next_s.header = set_header || (s.header && !clr_header);

    // error and stop flags live in the second status register
    next_s.ack_fail = set_ack_fail || (s.ack_fail && !rd_two);
    next_s.stop_det = set_stop_det || (s.stop_det && !rd_two);
    next_s.arb_lost = set_arb || (s.arb_lost && !rd_two);
    next_s.bus_err = set_bus_error_flag || (s.bus_err && !rd_two);

    if (set_start) begin
      next_s.master = 1'b1;
    end else if (cond_stop || set_arb) begin
      next_s.master = 1'b0;
    end

    if (set_match) begin
      next_s.slave_active = 1'b1;
    end else if (cond_stop || set_arb) begin
      next_s.slave_active = 1'b0;
    end

    // busy only moves while enabled, so it can be stale after enabling
    if (s.periph_en) begin
      if (cond_start) begin
        next_s.busy = 1'b1;
      end else if (cond_stop || set_bus_error_flag) begin
        next_s.busy = 1'b0;
      end
    end

    // which status register was read last
    if (rd_one) begin
      next_s.seq = SEQ_ONE;
    end else if (rd_two) begin
      next_s.seq = SEQ_TWO;
    end else if (wr_data || rd_data) begin
      next_s.seq = SEQ_NONE;
    end

    if (wr_data) begin
      next_s.tx_byte = wdata;
    end

    // summary is the or of everything that still asks for attention
    next_s.summary = next_s.byte_done || next_s.addr_match || next_s.start_gen || next_s.header
      || next_s.ack_fail || next_s.stop_det || next_s.arb_lost || next_s.bus_err;

    // disabling wipes control and flags, but keeps stop request and busy
    if (!next_s.periph_en) begin
      next_s.start_req = 1'b0;
      next_s.ack_en = 1'b0;
      next_s.int_en = 1'b0;
      next_s.summary = 1'b0;
      next_s.header = 1'b0;
      next_s.direction = 1'b0;
      next_s.byte_done = 1'b0;
      next_s.addr_match = 1'b0;
      next_s.master = 1'b0;
      next_s.start_gen = 1'b0;
      next_s.ack_fail = 1'b0;
      next_s.stop_det = 1'b0;
      next_s.arb_lost = 1'b0;
      next_s.bus_err = 1'b0;
      next_s.slave_active = 1'b0;
      next_s.seq = SEQ_NONE;
    end

    // stretch the clock while software still owes an answer
    next_s.scl_out = 1'b0;
    next_s.scl_oe = next_s.periph_en
      && (next_s.byte_done || next_s.addr_match || next_s.start_gen || next_s.header);

    // read data for one cycle; a write to the first status register stores nothing
    if (rd_en) begin
      case (addr)
        OFS_CTRL: next_s.rdata = view_ctrl;
        OFS_STATUS_ONE: next_s.rdata = view_one;
        OFS_STATUS_TWO: next_s.rdata = view_two;
        OFS_DATA: next_s.rdata = rx_byte;
        OFS_IRQ_STAT: next_s.rdata = link.stat;
        OFS_IRQ_MASK: next_s.rdata = link.mask;
        default: next_s.rdata = RST_BYTE;
      endcase
    end else begin
      next_s.rdata = RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{periph_en: 1'b0, start_req: 1'b0, ack_en: 1'b0, stop_req: 1'b0, int_en: 1'b0,
             summary: 1'b0, header: 1'b0, direction: 1'b0, busy: 1'b0, byte_done: 1'b0,
             addr_match: 1'b0, master: 1'b0, start_gen: 1'b0, ack_fail: 1'b0, stop_det: 1'b0,
             arb_lost: 1'b0, bus_err: 1'b0, slave_active: 1'b0, seq: SEQ_NONE,
             tx_byte: RST_BYTE, rdata: RST_BYTE, scl_out: 1'b0, scl_oe: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign rdata = s.rdata;
  assign scl_o = s.scl_out;
  assign scl_oe = s.scl_oe;
  assign tx_byte = s.tx_byte;
  assign peripheral_enable = s.periph_en;
  assign start_request = s.start_req;
  assign stop_request = s.stop_req;
  assign ack_enable = s.ack_en;
  assign master_mode_flag = s.master;
  assign irq = link.irq;

endmodule : isf_status_one

// ### tb/isf_status_one_asserts.sv
// concurrent checks on the ports of the first-status flag block
`timescale 1ns/1ps
module isf_status_one_asserts
  import isf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic ev_tx_byte_acked,
  input wire logic ev_rx_byte_acked,
  input wire logic ev_addr_acked,
  input wire logic ev_own_addr_match,
  input wire logic ev_start_issued,
  input wire logic ev_header_sent,
  input wire logic ev_arb_lost,
  input wire logic peripheral_enable,
  input wire logic start_request,
  input wire logic ack_enable,
  input wire logic master_mode_flag,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // no event other than a received byte that could raise a stretching flag in this cycle
  sequence s_quiet;
    !ev_tx_byte_acked && !ev_addr_acked && !ev_own_addr_match && !ev_start_issued && !ev_header_sent;
  endsequence
  sequence s_tx_done;
    peripheral_enable && ev_tx_byte_acked;
  endsequence
  sequence s_off_two;
    !peripheral_enable ##1 !peripheral_enable;
  endsequence

  property p_scl_drive;
    scl_o == 1'b0;
  endproperty
  property p_tx_stretch;
    s_tx_done |=> scl_oe;
  endproperty
  property p_match_stretch;
    peripheral_enable && ack_enable && ev_own_addr_match |=> scl_oe;
  endproperty
  property p_rx_refused;
    s_quiet and (ev_rx_byte_acked && !ack_enable && !scl_oe && !wr_en) |=> !scl_oe;
  endproperty
  property p_master_set;
    peripheral_enable && start_request && ev_start_issued |=> master_mode_flag;
  endproperty
  property p_arb_clear;
    peripheral_enable && ev_arb_lost && !ev_start_issued |=> !master_mode_flag;
  endproperty
  property p_disable;
    !peripheral_enable |-> !start_request && !ack_enable && !master_mode_flag;
  endproperty
  property p_release;
    s_off_two |-> !scl_oe && !irq;
  endproperty
  property p_status_write;
    s_quiet and (wr_en && addr == OFS_STATUS_ONE) |=> $stable(master_mode_flag) && $stable(scl_oe);
  endproperty

  a_scl_drive: assert property (p_scl_drive) else $error("scl drive value not low");
  a_tx_stretch: assert property (p_tx_stretch) else $error("no stretch after byte sent");
  a_match_stretch: assert property (p_match_stretch) else $error("no stretch on match");
  a_rx_refused: assert property (p_rx_refused) else $error("byte taken without ack");
  a_master_set: assert property (p_master_set) else $error("master not set on start");
  a_arb_clear: assert property (p_arb_clear) else $error("master kept after arb loss");
  a_disable: assert property (p_disable) else $error("control kept while disabled");
  a_release: assert property (p_release) else $error("outputs held while disabled");
  a_status_write: assert property (p_status_write) else $error("status write had effect");
endmodule : isf_status_one_asserts

bind isf_status_one isf_status_one_asserts i_isf_status_one_asserts (
  .clock(clock), .rst(rst), .addr(addr), .wr_en(wr_en), .scl_o(scl_o), .scl_oe(scl_oe),
  .ev_tx_byte_acked(ev_tx_byte_acked), .ev_rx_byte_acked(ev_rx_byte_acked), .ev_addr_acked(ev_addr_acked),
  .ev_own_addr_match(ev_own_addr_match), .ev_start_issued(ev_start_issued), .ev_header_sent(ev_header_sent),
  .ev_arb_lost(ev_arb_lost), .peripheral_enable(peripheral_enable), .start_request(start_request),
  .ack_enable(ack_enable), .master_mode_flag(master_mode_flag), .irq(irq));

// ### tb/isf_bus_model.sv
// far side of the bus: pulled-up lines and another master framing start and stop
`timescale 1ns/1ps
module isf_bus_model (
  input wire logic scl_o,
  input wire logic scl_oe,
  output logic scl,
  output logic sda
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  // wired and: our stretch wins over the other master's high
  assign scl = scl_drv & ~(scl_oe & ~scl_o);
  assign sda = sda_drv;

  ////////////////////////////////////////////////////////////////////////////////
  // half period of an 80 ns link clock; clock stands still outside frames
  task automatic start_cond;
    scl_drv = 1'b1;
    #40;
    sda_drv = 1'b0;
    #40;
    scl_drv = 1'b0;
    #40;
  endtask : start_cond
  task automatic stop_cond;
    sda_drv = 1'b0;
    #40;
    scl_drv = 1'b1;
    #40;
    sda_drv = 1'b1;
    #40;
  endtask : stop_cond
endmodule : isf_bus_model

// ### tb/isf_status_one_tb.sv
// self-checking bench of the first-status flag block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module isf_status_one_tb;
  import isf_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [8:0] ev_v = '0;
  logic [DATA_W-1:0] rdata, tx_byte, r;
  logic scl_o, scl_oe, scl, sda, pe, sreq, preq, ack_en, master, irq;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;

  isf_status_one i_isf_status_one (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe),
    .ev_tx_byte_acked(ev_v[0]), .ev_rx_byte_acked(ev_v[1]), .ev_addr_acked(ev_v[2]),
    .ev_own_addr_match(ev_v[3]), .ev_start_issued(ev_v[4]), .ev_header_sent(ev_v[5]),
    .ev_ack_missing(ev_v[6]), .ev_arb_lost(ev_v[7]), .ev_misplaced_cond(ev_v[8]), .rx_byte(8'h5A),
    .tx_byte(tx_byte), .peripheral_enable(pe), .start_request(sreq), .stop_request(preq),
    .ack_enable(ack_en), .master_mode_flag(master), .irq(irq));
  isf_bus_model i_isf_bus_model (.scl_o(scl_o), .scl_oe(scl_oe), .scl(scl), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic ev(input int i);
    @(posedge clock);
    ev_v <= 9'h001 << i;
    @(posedge clock);
    ev_v <= '0;
    #1;
  endtask : ev
  task automatic chk1(input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e, input string nm);
    rd(OFS_STATUS_ONE, r);
    `CHK(nm, e, r & m)
  endtask : chk1
  task automatic stop_test;
    $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // ceiling well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    chk1(8'hFF, 8'h00, "status reset");
    wr(OFS_STATUS_ONE, 8'hFF);
    chk1(8'hFF, 8'h00, "status write");
    rd(3'h7, r);
    `CHK("unmapped", 8'h00, r)
    wr(OFS_CTRL, 8'h20);
    wr(OFS_CTRL, 8'h25);
    wr(OFS_IRQ_MASK, 8'hFF);
    `CHK("ack_enable", 1'b1, ack_en)
    `CHK("enable", 1'b1, pe)
    rd(OFS_CTRL, r);
    `CHK("ctrl", 8'h25, r)
    chk1(8'hFF, 8'h00, "idle busy");
    i_isf_bus_model.start_cond();
    chk1(8'hFF, 8'h10, "busy on start");
    i_isf_bus_model.stop_cond();
    chk1(8'hFF, 8'h00, "busy off stop");
    $display("test registers and busy done");
    // data byte sent, then address byte acknowledged
    for (int i = 0; i < 3; i += 2) begin
      ev(i);
      `CHK("irq", 1'b1, irq)
      `CHK("scl", 1'b0, scl)
      chk1(8'hFF, 8'hA8, "tx byte done");
      wr(OFS_DATA, 8'h3C + 8'(i));
      `CHK("tx_byte", 8'h3C + 8'(i), tx_byte)
      wr(OFS_IRQ_STAT, 8'hFF);
      chk1(8'hFF, 8'h00, "tx cleared");
      `CHK("irq cleared", 1'b0, irq)
    end
    ev(1);
    chk1(8'hFF, 8'h88, "rx byte done");
    rd(OFS_DATA, r);
    `CHK("rx byte", 8'h5A, r)
    chk1(8'hFF, 8'h00, "rx cleared");
    ev(3);
    `CHK("scl match", 1'b0, scl)
    chk1(8'hFF, 8'h84, "match");
    chk1(8'hFF, 8'h00, "match cleared");
    // still addressed as slave, so the stop raises the second-status stop flag
    i_isf_bus_model.start_cond();
    i_isf_bus_model.stop_cond();
    chk1(8'hFF, 8'h80, "stop detected");
    rd(OFS_STATUS_TWO, r);
    `CHK("stop det", 8'h08, r)
    $display("test byte and match done");
    wr(OFS_CTRL, 8'h2D);
    `CHK("start request", 1'b1, sreq)
    ev(4);
    `CHK("start request cleared", 1'b0, sreq)
    `CHK("master", 1'b1, master)
    chk1(8'h83, 8'h83, "start gen");
    wr(OFS_DATA, 8'hA0);
    chk1(8'h01, 8'h00, "start cleared");
    ev(7);
    `CHK("master arb", 1'b0, master)
    rd(OFS_STATUS_TWO, r);
    wr(OFS_CTRL, 8'h25);
    ev(5);
    chk1(8'h40, 8'h40, "header");
    wr(OFS_DATA, 8'h11);
    chk1(8'h40, 8'h40, "header kept");
    rd(OFS_STATUS_TWO, r);
    wr(OFS_DATA, 8'h22);
    chk1(8'h40, 8'h00, "header cleared");
    $display("test start and header done");
    // error events with the bus busy; bus error must also end busy
    i_isf_bus_model.start_cond();
    for (int i = 6; i < 9; i++) begin
      ev(i);
      chk1(8'h80, 8'h80, "summary");
      rd(OFS_STATUS_TWO, r);
      chk1(8'h80, 8'h00, "summary cleared");
    end
    chk1(8'hFF, 8'h00, "busy bus error");
    i_isf_bus_model.stop_cond();
    wr(OFS_IRQ_STAT, 8'hFF);
    wr(OFS_CTRL, 8'h24);
    ev(0);
    `CHK("irq gated", 1'b0, irq)
    rd(OFS_IRQ_STAT, r);
    `CHK("irq status", 8'h01, r & 8'h01)
    chk1(8'h08, 8'h08, "gated byte done");
    wr(OFS_DATA, 8'h33);
    wr(OFS_IRQ_STAT, 8'hFF);
    // enabled but acknowledge off: received byte and own address are refused
    wr(OFS_CTRL, 8'h21);
    ev(1);
    ev(3);
    `CHK("scl_oe refused", 1'b0, scl_oe)
    chk1(8'hFF, 8'h00, "refused without ack");
    wr(OFS_CTRL, 8'h25);
    $display("test errors and interrupt done");
    // disable mid-transfer with a stretch held
    i_isf_bus_model.start_cond();
    ev(0);
    wr(OFS_CTRL, 8'h02);
    ev(1);
    `CHK("scl_oe off", 1'b0, scl_oe)
    `CHK("ack off", 1'b0, ack_en)
    `CHK("enable off", 1'b0, pe)
    `CHK("stop kept", 1'b1, preq)
    chk1(8'hFF, 8'h10, "disabled flags");
    i_isf_bus_model.stop_cond();
    wr(OFS_CTRL, 8'h20);
    chk1(8'hFF, 8'h10, "busy frozen");
    wr(OFS_CTRL, 8'h25);
    i_isf_bus_model.start_cond();
    i_isf_bus_model.stop_cond();
    chk1(8'hFF, 8'h00, "busy resync");
    $display("test disable done");
    stop_test();
  end
endmodule : isf_status_one_tb
